/* src/asp_pkg.sv */
package asp_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_DATA = 4'h1;
  localparam logic [3:0] ADR_RELOAD = 4'h2;
  localparam logic [3:0] ADR_COUNT = 4'h3;
  localparam logic [3:0] ADR_TCFG = 4'h4;

  // Serial control register bit positions
  localparam int B_MODE = 7;
  localparam int B_MCE = 5;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;

  // Timer configuration register fields
  localparam int B_TEN = 4;
  localparam int B_SEL_LSB = 0;

  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [2:0] PIN_RST = 3'h1;

  // Timer clock source codes
  localparam logic [2:0] CS_SYS = 3'h0;
  localparam logic [2:0] CS_DIV4 = 3'h1;
  localparam logic [2:0] CS_DIV12 = 3'h2;
  localparam logic [2:0] CS_DIV48 = 3'h3;
  localparam logic [2:0] CS_EXT8 = 3'h4;
  localparam logic [2:0] CS_PIN = 3'h5;

  // Prescaler last counts for divide by 4, 12 and 48, and the oscillator divide by 8
  localparam logic [2:0][5:0] DIV_LAST = {6'h2F, 6'h0B, 6'h03};
  localparam logic [2:0] EXT_LAST = 3'h7;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [5:0] {
    ASP_TX_IDLE = 6'h01,
    ASP_TX_LOAD = 6'h02,
    ASP_TX_START = 6'h04,
    ASP_TX_DATA = 6'h08,
    ASP_TX_NINTH = 6'h10,
    ASP_TX_STOP = 6'h20
  } asp_tx_state_t;

  typedef enum logic [4:0] {
    ASP_RX_IDLE = 5'h01,
    ASP_RX_START = 5'h02,
    ASP_RX_DATA = 5'h04,
    ASP_RX_NINTH = 5'h08,
    ASP_RX_STOP = 5'h10
  } asp_rx_state_t;

endpackage

/* src/asp_serial_port.sv */
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
module asp_serial_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  input wire logic baud_timer_ext_input_in,
  input wire logic ext_osc_in,
  input wire logic irq_enable_in,
  output logic irq_out
);

  // Register strobe decode
  wire logic wr_ctrl = wr_in && (addr_in == asp_pkg::ADR_CTRL);
  wire logic wr_data = wr_in && (addr_in == asp_pkg::ADR_DATA);
  wire logic wr_reload = wr_in && (addr_in == asp_pkg::ADR_RELOAD);
  wire logic wr_count = wr_in && (addr_in == asp_pkg::ADR_COUNT);
  wire logic wr_tcfg = wr_in && (addr_in == asp_pkg::ADR_TCFG);

  logic mode_r;
  logic mce_r;
  logic ren_r;
  logic tb8_r;
  logic rb8_r;
  logic ti_r;
  logic ri_r;
  logic ten_r;
  logic [2:0] sel_r;
  logic [7:0] reload_r;
  logic [7:0] tx_cnt_r;
  logic [7:0] rx_cnt_r;
  logic tx_half_r;
  logic rx_phase_r;
  logic [7:0] rx_buf_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic serial_out_r;

  // Pin synchronisers: 0 serial input, 1 timer input pin, 2 external oscillator
  wire logic [2:0] pin_raw = {ext_osc_in, baud_timer_ext_input_in, serial_in_pin_in};
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s3_r;
  logic [2:0] pin_lvl_r;
  logic [2:0] pin_prev_r;
  logic [2:0][5:0] pre_r;
  logic [2:0] pre_tick;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      // A level only counts once the second and third stages agree
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_s1_r[g] <= asp_pkg::PIN_RST[g];
          pin_s2_r[g] <= asp_pkg::PIN_RST[g];
          pin_s3_r[g] <= asp_pkg::PIN_RST[g];
          pin_lvl_r[g] <= asp_pkg::PIN_RST[g];
          pin_prev_r[g] <= asp_pkg::PIN_RST[g];
        end else begin
          pin_s1_r[g] <= pin_raw[g];
          pin_s2_r[g] <= pin_s1_r[g];
          pin_s3_r[g] <= pin_s2_r[g];
          if (pin_s2_r[g] == pin_s3_r[g]) begin
            pin_lvl_r[g] <= pin_s3_r[g];
          end
          pin_prev_r[g] <= pin_lvl_r[g];
        end
      end

      // System clock prescalers for divide by 4, 12 and 48
      assign pre_tick[g] = (pre_r[g] == asp_pkg::DIV_LAST[g]);
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pre_r[g] <= 6'h00;
        end else begin
          pre_r[g] <= pre_tick[g] ? 6'h00 : pre_r[g] + 6'h01;
        end
      end
    end
  endgenerate

  wire logic [2:0] pin_rise = pin_lvl_r & ~pin_prev_r;
  wire logic rx_line = pin_lvl_r[0];
  wire logic rx_fall = pin_prev_r[0] & ~pin_lvl_r[0];

  // Oscillator edges divided by eight
  logic [2:0] ext_cnt_r;
  wire logic ext_tick = pin_rise[2] && (ext_cnt_r == asp_pkg::EXT_LAST);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cnt_r <= 3'h0;
    end else if (pin_rise[2]) begin
      ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  // Timer clock source select; the pin source counts rising edges
  wire logic src_tick = (sel_r == asp_pkg::CS_SYS) ? 1'b1 :
    (sel_r == asp_pkg::CS_DIV4) ? pre_tick[0] :
    (sel_r == asp_pkg::CS_DIV12) ? pre_tick[1] :
    (sel_r == asp_pkg::CS_DIV48) ? pre_tick[2] :
    (sel_r == asp_pkg::CS_EXT8) ? ext_tick :
    (sel_r == asp_pkg::CS_PIN) ? pin_rise[1] : 1'b0;
  wire logic tmr_tick = ten_r && src_tick;

  // Transmit counter: auto-reload, overflow after 256 minus reload ticks
  wire logic tx_ovf = tmr_tick && (tx_cnt_r == asp_pkg::CNT_TOP);
  wire logic tx_bit_tick = tx_ovf && tx_half_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_cnt_r <= asp_pkg::COUNT_RST;
      tx_half_r <= 1'b0;
    end else begin
      if (wr_count) begin
        tx_cnt_r <= wdata_in;
      end else if (tx_ovf) begin
        tx_cnt_r <= reload_r;
      end else if (tmr_tick) begin
        tx_cnt_r <= tx_cnt_r + 8'h01;
      end
      if (tx_ovf) begin
        tx_half_r <= ~tx_half_r;
      end
    end
  end

  asp_pkg::asp_rx_state_t rx_state_r;
  asp_pkg::asp_rx_state_t rx_state_nxt;
  wire logic rx_start = (rx_state_r == asp_pkg::ASP_RX_IDLE) && ren_r && rx_fall;

  // Hidden receive counter; a start restarts it so the first overflow lands mid start bit
  wire logic rx_ovf = tmr_tick && (rx_cnt_r == asp_pkg::CNT_TOP) && !rx_start;
  wire logic rx_sample = rx_ovf && !rx_phase_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_cnt_r <= asp_pkg::COUNT_RST;
      rx_phase_r <= 1'b0;
    end else if (rx_start) begin
      rx_cnt_r <= reload_r;
      rx_phase_r <= 1'b0;
    end else if (rx_ovf) begin
      rx_cnt_r <= reload_r;
      rx_phase_r <= ~rx_phase_r;
    end else if (tmr_tick) begin
      rx_cnt_r <= rx_cnt_r + 8'h01;
    end
  end

  // Transmit sequencer; a write while busy is dropped so a frame is never cut short
  asp_pkg::asp_tx_state_t tx_state_r;
  asp_pkg::asp_tx_state_t tx_state_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic [2:0] tx_idx_r;
  logic [2:0] tx_idx_nxt;
  logic serial_out_nxt;
  logic ti_set;
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt = tx_sh_r;
    tx_idx_nxt = tx_idx_r;
    serial_out_nxt = serial_out_r;
    ti_set = 1'b0;
    case (tx_state_r)
      asp_pkg::ASP_TX_IDLE: begin
        serial_out_nxt = 1'b1;
        if (wr_data) begin
          tx_sh_nxt = wdata_in;
          tx_state_nxt = asp_pkg::ASP_TX_LOAD;
        end
      end
      asp_pkg::ASP_TX_LOAD: begin
        if (tx_bit_tick) begin
          serial_out_nxt = 1'b0;
          tx_state_nxt = asp_pkg::ASP_TX_START;
        end
      end
      asp_pkg::ASP_TX_START: begin
        if (tx_bit_tick) begin
          serial_out_nxt = tx_sh_r[0];
          tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
          tx_idx_nxt = 3'h0;
          tx_state_nxt = asp_pkg::ASP_TX_DATA;
        end
      end
      asp_pkg::ASP_TX_DATA: begin
        if (tx_bit_tick) begin
          if (tx_idx_r == asp_pkg::LAST_BIT) begin
            if (mode_r) begin
              serial_out_nxt = tb8_r;
              tx_state_nxt = asp_pkg::ASP_TX_NINTH;
            end else begin
              serial_out_nxt = 1'b1;
              ti_set = 1'b1;
              tx_state_nxt = asp_pkg::ASP_TX_STOP;
            end
          end else begin
            serial_out_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
            tx_idx_nxt = tx_idx_r + 3'h1;
          end
        end
      end
      asp_pkg::ASP_TX_NINTH: begin
        if (tx_bit_tick) begin
          serial_out_nxt = 1'b1;
          ti_set = 1'b1;
          tx_state_nxt = asp_pkg::ASP_TX_STOP;
        end
      end
      asp_pkg::ASP_TX_STOP: begin
        if (tx_bit_tick) begin
          tx_state_nxt = asp_pkg::ASP_TX_IDLE;
        end
      end
      default: begin
        serial_out_nxt = 1'b1;
        tx_state_nxt = asp_pkg::ASP_TX_IDLE;
      end
    endcase
  end

  // Receive sequencer; shifter is apart from the buffer so a new frame can arrive
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [2:0] rx_idx_r;
  logic [2:0] rx_idx_nxt;
  logic rx_bit9_r;
  logic rx_bit9_nxt;
  logic rx_done;
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt = rx_sh_r;
    rx_idx_nxt = rx_idx_r;
    rx_bit9_nxt = rx_bit9_r;
    rx_done = 1'b0;
    case (rx_state_r)
      asp_pkg::ASP_RX_IDLE: begin
        if (rx_start) begin
          rx_state_nxt = asp_pkg::ASP_RX_START;
        end
      end
      asp_pkg::ASP_RX_START: begin
        if (rx_sample) begin
          rx_idx_nxt = 3'h0;
          rx_state_nxt = rx_line ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
        end
      end
      asp_pkg::ASP_RX_DATA: begin
        if (rx_sample) begin
          rx_sh_nxt = {rx_line, rx_sh_r[7:1]};
          rx_idx_nxt = rx_idx_r + 3'h1;
          if (rx_idx_r == asp_pkg::LAST_BIT) begin
            rx_state_nxt = mode_r ? asp_pkg::ASP_RX_NINTH : asp_pkg::ASP_RX_STOP;
          end
        end
      end
      asp_pkg::ASP_RX_NINTH: begin
        if (rx_sample) begin
          rx_bit9_nxt = rx_line;
          rx_state_nxt = asp_pkg::ASP_RX_STOP;
        end
      end
      asp_pkg::ASP_RX_STOP: begin
        if (rx_sample) begin
          rx_done = 1'b1;
          rx_state_nxt = asp_pkg::ASP_RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = asp_pkg::ASP_RX_IDLE;
      end
    endcase
  end

  // Flag bit is the stop bit in 8-bit frames, the ninth bit in 9-bit frames
  wire logic rx_flag = mode_r ? rx_bit9_r : rx_line;
  wire logic rx_load = rx_done && !ri_r && (!mce_r || rx_flag);

  // Sequencer state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state_r <= asp_pkg::ASP_TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_idx_r <= 3'h0;
      serial_out_r <= 1'b1;
      rx_state_r <= asp_pkg::ASP_RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_idx_r <= 3'h0;
      rx_bit9_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_idx_r <= tx_idx_nxt;
      serial_out_r <= serial_out_nxt;
      rx_state_r <= rx_state_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_bit9_r <= rx_bit9_nxt;
    end
  end

  // Control bits; hardware set wins over a software clear in the same cycle
  wire logic ti_nxt = ti_set || (wr_ctrl ? wdata_in[asp_pkg::B_TI] : ti_r);
  wire logic ri_nxt = rx_load || (wr_ctrl ? wdata_in[asp_pkg::B_RI] : ri_r);
  wire logic rb8_nxt = rx_load ? rx_flag : (wr_ctrl ? wdata_in[asp_pkg::B_RB8] : rb8_r);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= 1'b0;
      mce_r <= 1'b0;
      ren_r <= 1'b0;
      tb8_r <= 1'b0;
      rb8_r <= 1'b0;
      ti_r <= 1'b0;
      ri_r <= 1'b0;
      rx_buf_r <= 8'h00;
      reload_r <= asp_pkg::RELOAD_RST;
      ten_r <= 1'b0;
      sel_r <= asp_pkg::SEL_RST;
    end else begin
      if (wr_ctrl) begin
        mode_r <= wdata_in[asp_pkg::B_MODE];
        mce_r <= wdata_in[asp_pkg::B_MCE];
        ren_r <= wdata_in[asp_pkg::B_REN];
        tb8_r <= wdata_in[asp_pkg::B_TB8];
      end
      rb8_r <= rb8_nxt;
      ti_r <= ti_nxt;
      ri_r <= ri_nxt;
      if (rx_load) begin
        rx_buf_r <= rx_sh_r;
      end
      if (wr_reload) begin
        reload_r <= wdata_in;
      end
      if (wr_tcfg) begin
        ten_r <= wdata_in[asp_pkg::B_TEN];
        sel_r <= wdata_in[asp_pkg::B_SEL_LSB +: 3];
      end
    end
  end

  // Read path; the transmit shifter has no read view at all
  wire logic [7:0] ctrl_view = {mode_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
  wire logic [7:0] tcfg_view = {3'h0, ten_r, 1'b0, sel_r};
  wire logic [7:0] rd_mux = (addr_in == asp_pkg::ADR_CTRL) ? ctrl_view :
    (addr_in == asp_pkg::ADR_DATA) ? rx_buf_r :
    (addr_in == asp_pkg::ADR_RELOAD) ? reload_r :
    (addr_in == asp_pkg::ADR_COUNT) ? tx_cnt_r :
    (addr_in == asp_pkg::ADR_TCFG) ? tcfg_view : 8'h00;

  // Read data and interrupt request registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rd_in ? rd_mux : 8'h00;
      irq_r <= irq_enable_in && (ti_r || ri_r);
    end
  end

  assign rdata_out = rdata_r;
  assign serial_out_pin_out = serial_out_r;
  assign irq_out = irq_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_read_rx_buf: assert property (rd_in && addr_in == asp_pkg::ADR_DATA |=> rdata_out == $past(rx_buf_r))
    else $error("data read did not return receive buffer");
  a_ti_sticky: assert property (ti_r && !wr_ctrl |=> ti_r)
    else $error("transmit done cleared without write");
  a_ri_sticky: assert property (ri_r && !wr_ctrl |=> ri_r)
    else $error("receive done cleared without write");
  a_overrun_hold: assert property (ri_r |=> $stable(rx_buf_r))
    else $error("receive buffer changed while full");
  a_ti_at_stop: assert property ($rose(tx_state_r == asp_pkg::ASP_TX_STOP) |-> ti_r && serial_out_pin_out)
    else $error("transmit done not set at stop");
  a_start_low: assert property (tx_state_r == asp_pkg::ASP_TX_START |-> !serial_out_pin_out)
    else $error("start bit not low");
  a_idle_high: assert property (tx_state_r == asp_pkg::ASP_TX_IDLE |-> serial_out_pin_out)
    else $error("line not idle high");
  a_ninth_mode: assert property (tx_state_r == asp_pkg::ASP_TX_NINTH |-> mode_r)
    else $error("ninth bit sent in 8-bit format");
  a_rx_restart: assert property (rx_start |=> rx_cnt_r == $past(reload_r) && !rx_phase_r)
    else $error("receive counter not restarted");
  a_ren_gate: assert property (rx_state_r == asp_pkg::ASP_RX_IDLE && !ren_r |=> rx_state_r == asp_pkg::ASP_RX_IDLE)
    else $error("receiver left idle while disabled");
  a_filter: assert property ($rose(ri_r) |-> $past(!mce_r || rx_flag))
    else $error("filtered frame raised receive done");
  a_irq: assert property (irq_enable_in && (ti_r || ri_r) |=> irq_out)
    else $error("interrupt request not raised");
  a_bit_half: assert property (tx_ovf && !tx_half_r |-> !tx_bit_tick ##1 tx_half_r)
    else $error("bit tick on odd overflow");

endmodule

/* tb/asp_remote_node.sv */
`timescale 1ns/10ps
// Far-end serial node; bit time is set in ns so it is free of the device clock
module asp_remote_node (
  input wire logic tx_line_in,
  output logic rx_line_out
);
  int bit_ns = 3200;
  bit nine = 1'b0;
  int start_count = 0;
  int rx_count = 0;
  logic [7:0] got_data;
  logic got_ninth;
  logic got_stop;

  // Line rests high outside frames
  initial begin
    rx_line_out = 1'b1;
  end

  // Sender; a set ninth bit marks an address frame, data frames carry zero
  task automatic send_frame(input logic [7:0] d, input logic ninth, input logic stop);
    rx_line_out = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rx_line_out = d[i];
      #(bit_ns);
    end
    if (nine) begin
      rx_line_out = ninth;
      #(bit_ns);
    end
    rx_line_out = stop;
    #(bit_ns);
    rx_line_out = 1'b1;
  endtask

  // Receiver samples mid-bit; no start check, so a short start shows as bad data
  always begin
    @(negedge tx_line_in);
    start_count++;
    #(bit_ns / 2);
    for (int i = 0; i < 8; i++) begin
      #(bit_ns);
      got_data[i] = tx_line_in;
    end
    if (nine) begin
      #(bit_ns);
      got_ninth = tx_line_in;
    end
    #(bit_ns);
    got_stop = tx_line_in;
    rx_count++;
  end
endmodule

/* tb/asp_serial_port_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench; remote node plays the far end of the serial line
module asp_serial_port_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic serial_in_pin_in;
  logic serial_out_pin_out;
  logic baud_timer_ext_input_in = 1'b0;
  logic ext_osc_in = 1'b0;
  logic irq_enable_in = 1'b1;
  logic irq_out;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] rv;

  // System clock, plus a slow offset clock on both external timer inputs
  always #50 clk_in = ~clk_in;
  // Each level lasts three clocks so the agreeing synchroniser stages always see it
  initial #20 forever #300 begin
    ext_osc_in = ~ext_osc_in;
    baud_timer_ext_input_in = ~baud_timer_ext_input_in;
  end

  asp_serial_port asp_serial_port_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .serial_in_pin_in(serial_in_pin_in),
    .serial_out_pin_out(serial_out_pin_out),
    .baud_timer_ext_input_in(baud_timer_ext_input_in),
    .ext_osc_in(ext_osc_in),
    .irq_enable_in(irq_enable_in),
    .irq_out(irq_out)
  );

  asp_remote_node asp_remote_node_inst (
    .tx_line_in(serial_out_pin_out),
    .rx_line_out(serial_in_pin_in)
  );

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register bus: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    rv = rdata_out;
    chk(rv, exp);
  endtask

  // Bounded wait on the remote's start or frame counter
  task automatic wait_far(input bit on_start, input int n);
    for (int k = 0; k < 3000; k++) begin
      if ((on_start ? asp_remote_node_inst.start_count : asp_remote_node_inst.rx_count) >= n) break;
      @(posedge clk_in);
    end
  endtask

  // Receive a frame and let the stop sample clear the synchroniser
  task automatic rx_frame(input logic [7:0] d, input logic ninth, input logic stop);
    asp_remote_node_inst.send_frame(d, ninth, stop);
    repeat (6) @(posedge clk_in);
  endtask

  task automatic t_reset_values();
    rc(asp_pkg::ADR_CTRL, 8'h40);
    rc(asp_pkg::ADR_DATA, 8'h00);
    rc(asp_pkg::ADR_RELOAD, 8'h00);
    rc(asp_pkg::ADR_TCFG, 8'h00);
    rc(4'hF, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
  endtask

  // Transmit once from every timer source; the remote times bits in ns
  task automatic t_sources();
    logic [2:0] src [6];
    logic [7:0] rl [6];
    int bns [6];
    logic [7:0] d;
    int s;
    int n;
    src = '{asp_pkg::CS_SYS, asp_pkg::CS_DIV4, asp_pkg::CS_DIV12, asp_pkg::CS_DIV48, asp_pkg::CS_EXT8, asp_pkg::CS_PIN};
    rl = '{8'hF0, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFE};
    bns = '{3200, 1600, 2400, 9600, 9600, 2400};
    for (int i = 0; i < 6; i++) begin
      d = {src[i], 5'h15};
      wr(asp_pkg::ADR_CTRL, 8'h10);
      wr(asp_pkg::ADR_RELOAD, rl[i]);
      wr(asp_pkg::ADR_TCFG, {5'h02, src[i]});
      asp_remote_node_inst.bit_ns = bns[i];
      s = asp_remote_node_inst.start_count;
      n = asp_remote_node_inst.rx_count;
      wr(asp_pkg::ADR_DATA, d);
      wait_far(1'b1, s + 1);
      rc(asp_pkg::ADR_CTRL, 8'h50);
      wait_far(1'b0, n + 1);
      chk(asp_remote_node_inst.got_data, d);
      chk({7'h00, asp_remote_node_inst.got_stop}, 8'h01);
      rc(asp_pkg::ADR_CTRL, 8'h52);
      rc(asp_pkg::ADR_DATA, 8'h00);
      // Let the stop bit finish before the source changes, or the next write is dropped
      repeat (bns[i] / 100) @(posedge clk_in);
    end
  endtask

  // Receive, interrupt gating, overrun and a back-to-back pair
  task automatic t_rx();
    wr(asp_pkg::ADR_RELOAD, 8'hF0);
    wr(asp_pkg::ADR_TCFG, 8'h10);
    asp_remote_node_inst.bit_ns = 3200;
    wr(asp_pkg::ADR_CTRL, 8'h10);
    rx_frame(8'h3C, 1'b0, 1'b1);
    rc(asp_pkg::ADR_DATA, 8'h3C);
    rc(asp_pkg::ADR_CTRL, 8'h55);
    chk({7'h00, irq_out}, 8'h01);
    @(posedge clk_in);
    irq_enable_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk({7'h00, irq_out}, 8'h00);
    @(posedge clk_in);
    irq_enable_in <= 1'b1;
    rx_frame(8'hC7, 1'b0, 1'b1);
    rc(asp_pkg::ADR_DATA, 8'h3C);
    rc(asp_pkg::ADR_CTRL, 8'h55);
    wr(asp_pkg::ADR_CTRL, 8'h10);
    rc(asp_pkg::ADR_CTRL, 8'h50);
    chk({7'h00, irq_out}, 8'h00);
    rx_frame(8'hA1, 1'b0, 1'b1);
    fork
      asp_remote_node_inst.send_frame(8'hB2, 1'b0, 1'b1);
      begin
        repeat (20) @(posedge clk_in);
        rc(asp_pkg::ADR_DATA, 8'hA1);
        wr(asp_pkg::ADR_CTRL, 8'h10);
      end
    join
    repeat (6) @(posedge clk_in);
    rc(asp_pkg::ADR_DATA, 8'hB2);
  endtask

  // 8-bit stop check under the filter
  task automatic t_filter8();
    wr(asp_pkg::ADR_CTRL, 8'h30);
    rx_frame(8'h66, 1'b0, 1'b0);
    rc(asp_pkg::ADR_CTRL, 8'h70);
    rc(asp_pkg::ADR_DATA, 8'hB2);
    rx_frame(8'h99, 1'b0, 1'b1);
    rc(asp_pkg::ADR_DATA, 8'h99);
    rc(asp_pkg::ADR_CTRL, 8'h75);
  endtask

  // 9-bit: address then data under the filter, unfiltered load, 9-bit send
  task automatic t_nine();
    int n;
    asp_remote_node_inst.nine = 1'b1;
    wr(asp_pkg::ADR_CTRL, 8'hB0);
    rx_frame(8'h9A, 1'b1, 1'b0);
    rc(asp_pkg::ADR_DATA, 8'h9A);
    rc(asp_pkg::ADR_CTRL, 8'hF5);
    wr(asp_pkg::ADR_CTRL, 8'hB0);
    rx_frame(8'h55, 1'b0, 1'b1);
    rc(asp_pkg::ADR_CTRL, 8'hF0);
    rc(asp_pkg::ADR_DATA, 8'h9A);
    wr(asp_pkg::ADR_CTRL, 8'h98);
    rx_frame(8'h4E, 1'b0, 1'b1);
    rc(asp_pkg::ADR_DATA, 8'h4E);
    rc(asp_pkg::ADR_CTRL, 8'hD9);
    n = asp_remote_node_inst.rx_count;
    wr(asp_pkg::ADR_DATA, 8'hC3);
    wait_far(1'b0, n + 1);
    chk(asp_remote_node_inst.got_data, 8'hC3);
    chk({7'h00, asp_remote_node_inst.got_ninth}, 8'h01);
    chk({7'h00, asp_remote_node_inst.got_stop}, 8'h01);
    rc(asp_pkg::ADR_CTRL, 8'hDB);
  endtask

  // Frames are ignored while the receive enable is clear
  task automatic t_disabled();
    asp_remote_node_inst.nine = 1'b0;
    wr(asp_pkg::ADR_CTRL, 8'h00);
    rx_frame(8'h24, 1'b0, 1'b1);
    rc(asp_pkg::ADR_CTRL, 8'h40);
    rc(asp_pkg::ADR_DATA, 8'h4E);
  endtask

  // Cut a hang short; the full run needs roughly 7.5k cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset_values();
    t_sources();
    t_rx();
    t_filter8();
    t_nine();
    t_disabled();
    summarize();
  end
endmodule
